// file: shared/ppg_pkg.sv
package ppg_pkg;

    localparam int unsigned PIN_COUNT = 32;
    localparam int unsigned HALF_WIDTH = 16;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned ADDR_WIDTH = 17;
    localparam int unsigned IDX_WIDTH = 15;
    localparam int unsigned SYNC_STAGES = 2;

    typedef logic [HALF_WIDTH-1:0] ppg_half_t;
    typedef logic [IDX_WIDTH-1:0] ppg_idx_t;

    // Register indices; the byte address is four times the index.
    localparam ppg_idx_t IDX_DIR_LOW = 15'h4401;
    localparam ppg_idx_t IDX_LEVEL_LOW = 15'h4402;
    localparam ppg_idx_t IDX_EN_MID = 15'h4403;
    localparam ppg_idx_t IDX_DIR_MID = 15'h4404;
    localparam ppg_idx_t IDX_LEVEL_SNAP = 15'h4410;
    localparam ppg_idx_t IDX_DRIVE_STAT = 15'h4411;

    localparam ppg_half_t DIR_LOW_RESET = 16'h0000;
    localparam ppg_half_t EN_MID_RESET = 16'h0000;
    localparam ppg_half_t DIR_MID_RESET = 16'h0000;

endpackage

// file: shared/ppg_pin_if.sv
`timescale 1ns/1ps
interface ppg_pin_if #(parameter int unsigned WIDTH = ppg_pkg::PIN_COUNT);
    logic [WIDTH-1:0] en;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] dat;
    logic bus_owns;
    logic [WIDTH-1:0] drive_active;

    modport ctl (output en, output dir, output dat, output bus_owns, input drive_active);
    modport drv (input en, input dir, input dat, input bus_owns, output drive_active);
endinterface // ppg_pin_if

// file: verilog/ppg_pin_sync.sv
`timescale 1ns/1ps
module ppg_pin_sync #(
    parameter int unsigned WIDTH = ppg_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Raw pad levels and their synchronised copy
    input wire logic [WIDTH-1:0] pad_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second; the pads are asynchronous to the core.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_sync
            always_ff @(posedge clk_sys_in)
            begin
                meta_q[g] <= pad_in[g];
                level_out[g] <= meta_q[g];
            end
        end
    endgenerate

    property p_sync_delay;
        @(posedge clk_sys_in) disable iff (srst_in)
        1'b1 |-> ##2 (level_out == $past(pad_in, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Pin level not synchronised in two cycles.");

endmodule // ppg_pin_sync

// file: verilog/ppg_pin_drive.sv
`timescale 1ns/1ps
module ppg_pin_drive #(
    parameter int unsigned WIDTH = ppg_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Pin controls
    ppg_pin_if.drv pins,
    // Pads
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_oe_n_out
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            always_ff @(posedge clk_sys_in)
            begin
                if (srst_in)
                begin
                    pad_out[g] <= 1'b0;
                    pad_oe_n_out[g] <= 1'b1;
                end
                else
                begin
                    pad_out[g] <= pins.dat[g];
                    // The bus select wins over the enable bit, which only gates a freed pin.
                    pad_oe_n_out[g] <= ~(pins.en[g] & ~pins.bus_owns & pins.dir[g]);
                end
            end
        end
    endgenerate

    assign pins.drive_active = ~pad_oe_n_out;

    property p_input_released;
        @(posedge clk_sys_in) disable iff (srst_in)
        1'b1 |=> ((~$past(pins.dir) & ~pad_oe_n_out) == '0);
    endproperty
    a_input_released: assert property (p_input_released) else $error("Input pin is being driven.");

    property p_out_level;
        @(posedge clk_sys_in) disable iff (srst_in)
        1'b1 |=> ((~pad_oe_n_out & (pad_out ^ $past(pins.dat))) == '0);
    endproperty
    a_out_level: assert property (p_out_level) else $error("Driven pin level differs from data bit.");

    property p_disabled_hiz;
        @(posedge clk_sys_in) disable iff (srst_in)
        1'b1 |=> ((~$past(pins.en) & ~pad_oe_n_out) == '0);
    endproperty
    a_disabled_hiz: assert property (p_disabled_hiz) else $error("Disabled pin is not high impedance.");

    property p_enabled_drives;
        @(posedge clk_sys_in) disable iff (srst_in)
        !pins.bus_owns |=> (((pad_oe_n_out) & $past(pins.en) & $past(pins.dir)) == '0);
    endproperty
    a_enabled_drives: assert property (p_enabled_drives) else $error("Enabled output pin is not driven.");

    sequence s_bus_owned;
        pins.bus_owns;
    endsequence

    property p_bus_override;
        @(posedge clk_sys_in) disable iff (srst_in)
        s_bus_owned |=> (&pad_oe_n_out);
    endproperty
    a_bus_override: assert property (p_bus_override) else $error("Enable bit overrode the bus select.");

endmodule // ppg_pin_drive

// file: verilog/ppg_gpio_bank.sv
`timescale 1ns/1ps
module ppg_gpio_bank (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Avalon-MM slave
    input wire logic [ppg_pkg::ADDR_WIDTH-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [ppg_pkg::DATA_WIDTH-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [ppg_pkg::DATA_WIDTH-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Neighbouring register blocks and bus select
    input wire logic [ppg_pkg::HALF_WIDTH-1:0] pin_function_enable_low_in,
    input wire logic [ppg_pkg::HALF_WIDTH-1:0] pin_level_mid_in,
    input wire logic bus_select_owns_pins_in,
    // Pads
    input wire logic [ppg_pkg::PIN_COUNT-1:0] pad_in,
    output logic [ppg_pkg::PIN_COUNT-1:0] pad_out,
    output logic [ppg_pkg::PIN_COUNT-1:0] pad_oe_n_out,
    // Synchronised pin levels for the neighbouring data register
    output logic [ppg_pkg::PIN_COUNT-1:0] pin_level_sync_out
);

    ppg_pkg::ppg_half_t dir_low_q;
    ppg_pkg::ppg_half_t level_low_q;
    ppg_pkg::ppg_half_t level_low_d;
    ppg_pkg::ppg_half_t en_mid_q;
    ppg_pkg::ppg_half_t dir_mid_q;
    ppg_pkg::ppg_idx_t req_idx;
    logic wait_q;
    logic wr_go;
    logic rd_take;
    logic [ppg_pkg::DATA_WIDTH-1:0] rd_value;
    logic [ppg_pkg::DATA_WIDTH-1:0] rdata_q;
    logic [ppg_pkg::PIN_COUNT-1:0] sync_level;

    ppg_pin_if #(.WIDTH(ppg_pkg::PIN_COUNT)) pins ();

    function automatic logic reg_hit(input ppg_pkg::ppg_idx_t idx, input ppg_pkg::ppg_idx_t target);
        reg_hit = (idx == target);
    endfunction

    // Only the four control registers and the two read-only status words decode.
    function automatic logic reg_mapped(input ppg_pkg::ppg_idx_t idx);
        reg_mapped = reg_hit(idx, ppg_pkg::IDX_DIR_LOW) || reg_hit(idx, ppg_pkg::IDX_LEVEL_LOW)
            || reg_hit(idx, ppg_pkg::IDX_EN_MID) || reg_hit(idx, ppg_pkg::IDX_DIR_MID)
            || reg_hit(idx, ppg_pkg::IDX_LEVEL_SNAP) || reg_hit(idx, ppg_pkg::IDX_DRIVE_STAT);
    endfunction

    function automatic ppg_pkg::ppg_half_t lane_merge(
        input ppg_pkg::ppg_half_t old_val,
        input logic [ppg_pkg::DATA_WIDTH-1:0] wdata,
        input logic [3:0] be
    );
        lane_merge = old_val;
        if (be[0])
        begin
            lane_merge[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            lane_merge[15:8] = wdata[15:8];
        end
    endfunction

    ppg_pin_sync #(.WIDTH(ppg_pkg::PIN_COUNT)) u_sync (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .pad_in(pad_in),
        .level_out(sync_level)
    );

    ppg_pin_drive #(.WIDTH(ppg_pkg::PIN_COUNT)) u_drive (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .pins(pins.drv),
        .pad_out(pad_out),
        .pad_oe_n_out(pad_oe_n_out)
    );

    assign pin_level_sync_out = sync_level;

    // Low set bit n serves pin n; mid set bit n serves pin 16 + n.
    assign pins.en = {en_mid_q, pin_function_enable_low_in};
    assign pins.dir = {dir_mid_q, dir_low_q};
    assign pins.dat = {pin_level_mid_in, level_low_q};
    assign pins.bus_owns = bus_select_owns_pins_in;

    assign req_idx = avs_address_in[ppg_pkg::ADDR_WIDTH-1:2];
    // A read is latched on the first cycle; a write lands on the edge that sees waitrequest low.
    assign rd_take = avs_read_in & wait_q;
    assign wr_go = avs_write_in & ~wait_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            wait_q <= 1'b1;
        end
        else if (!wait_q)
        begin
            wait_q <= 1'b1;
        end
        else if (avs_read_in || avs_write_in)
        begin
            wait_q <= 1'b0;
        end
    end

    assign avs_waitrequest_out = wait_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            dir_low_q <= ppg_pkg::DIR_LOW_RESET;
        end
        else if (wr_go && reg_hit(req_idx, ppg_pkg::IDX_DIR_LOW))
        begin
            dir_low_q <= lane_merge(dir_low_q, avs_writedata_in, avs_byteenable_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            en_mid_q <= ppg_pkg::EN_MID_RESET;
        end
        else if (wr_go && reg_hit(req_idx, ppg_pkg::IDX_EN_MID))
        begin
            en_mid_q <= lane_merge(en_mid_q, avs_writedata_in, avs_byteenable_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            dir_mid_q <= ppg_pkg::DIR_MID_RESET;
        end
        else if (wr_go && reg_hit(req_idx, ppg_pkg::IDX_DIR_MID))
        begin
            dir_mid_q <= lane_merge(dir_mid_q, avs_writedata_in, avs_byteenable_in);
        end
    end

    // Input bits track the pin every cycle, so turning a pin into an output starts it at
    // its present level instead of a stale value. A write to an input bit is not kept.
    always_comb
    begin
        level_low_d = level_low_q;
        if (wr_go && reg_hit(req_idx, ppg_pkg::IDX_LEVEL_LOW))
        begin
            level_low_d = lane_merge(level_low_q, avs_writedata_in, avs_byteenable_in);
        end
        level_low_d = (dir_low_q & level_low_d) | (~dir_low_q & sync_level[ppg_pkg::HALF_WIDTH-1:0]);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            // No fixed value: the reset loads whatever level the pins show.
            level_low_q <= sync_level[ppg_pkg::HALF_WIDTH-1:0];
        end
        else
        begin
            level_low_q <= level_low_d;
        end
    end

    always_comb
    begin
        rd_value = '0;
        if (reg_hit(req_idx, ppg_pkg::IDX_DIR_LOW))
        begin
            rd_value[ppg_pkg::HALF_WIDTH-1:0] = dir_low_q;
        end
        else if (reg_hit(req_idx, ppg_pkg::IDX_LEVEL_LOW))
        begin
            rd_value[ppg_pkg::HALF_WIDTH-1:0] = level_low_q;
        end
        else if (reg_hit(req_idx, ppg_pkg::IDX_EN_MID))
        begin
            rd_value[ppg_pkg::HALF_WIDTH-1:0] = en_mid_q;
        end
        else if (reg_hit(req_idx, ppg_pkg::IDX_DIR_MID))
        begin
            rd_value[ppg_pkg::HALF_WIDTH-1:0] = dir_mid_q;
        end
        else if (reg_hit(req_idx, ppg_pkg::IDX_LEVEL_SNAP))
        begin
            rd_value = sync_level;
        end
        else if (reg_hit(req_idx, ppg_pkg::IDX_DRIVE_STAT))
        begin
            rd_value = pins.drive_active;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            rdata_q <= '0;
        end
        else if (rd_take)
        begin
            rdata_q <= rd_value;
        end
    end

    assign avs_readdata_out = rdata_q;

    sequence s_request_waiting;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence

    sequence s_answer;
        !avs_waitrequest_out;
    endsequence

    property p_bus_answer;
        @(posedge clk_sys_in) disable iff (srst_in)
        s_request_waiting |=> s_answer ##1 avs_waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("Bus request not answered after one wait cycle.");

    property p_dir_mid_write;
        @(posedge clk_sys_in) disable iff (srst_in)
        (avs_write_in && !avs_waitrequest_out && req_idx == ppg_pkg::IDX_DIR_MID && avs_byteenable_in == 4'hf)
        |=> (dir_mid_q == $past(avs_writedata_in[ppg_pkg::HALF_WIDTH-1:0])) ##1 (pins.dir[31:16] == $past(dir_mid_q));
    endproperty
    a_dir_mid_write: assert property (p_dir_mid_write) else $error("Mid direction write not applied to pins 31..16.");

    property p_input_follows_pin;
        @(posedge clk_sys_in) disable iff (srst_in)
        1'b1 |=> (((~$past(dir_low_q)) & (level_low_q ^ $past(sync_level[ppg_pkg::HALF_WIDTH-1:0]))) == '0);
    endproperty
    a_input_follows_pin: assert property (p_input_follows_pin) else $error("Input data bit does not show the pin.");

    property p_reset_level;
        @(posedge clk_sys_in) disable iff (srst_in)
        $fell(srst_in) |-> (level_low_q == $past(sync_level[ppg_pkg::HALF_WIDTH-1:0]));
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("Data bits after reset differ from pin levels.");

    property p_read_level_low;
        @(posedge clk_sys_in) disable iff (srst_in)
        (rd_take && req_idx == ppg_pkg::IDX_LEVEL_LOW)
        |=> (avs_readdata_out == {16'h0000, $past(level_low_q)}) && !avs_waitrequest_out;
    endproperty
    a_read_level_low: assert property (p_read_level_low) else $error("Data register read returned a wrong value.");

    // An idle slave must not answer a request that was never made.
    property p_wait_idle;
        @(posedge clk_sys_in) disable iff (srst_in)
        (!avs_read_in && !avs_write_in && avs_waitrequest_out) |=> avs_waitrequest_out;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("Waitrequest fell without a request.");

    property p_unmapped_read;
        @(posedge clk_sys_in) disable iff (srst_in)
        (rd_take && !reg_mapped(req_idx)) |=> (avs_readdata_out == '0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read returned nonzero data.");

    property p_reset_controls;
        @(posedge clk_sys_in) disable iff (srst_in)
        $fell(srst_in) |-> (dir_low_q == ppg_pkg::DIR_LOW_RESET) && (en_mid_q == ppg_pkg::EN_MID_RESET)
            && (dir_mid_q == ppg_pkg::DIR_MID_RESET) && (&pad_oe_n_out);
    endproperty
    a_reset_controls: assert property (p_reset_controls) else $error("Reset left controls set.");

    // Output bits keep what software wrote; only a data write may change them.
    property p_output_bit_holds;
        @(posedge clk_sys_in) disable iff (srst_in)
        !(wr_go && reg_hit(req_idx, ppg_pkg::IDX_LEVEL_LOW))
        |=> (($past(dir_low_q) & (level_low_q ^ $past(level_low_q))) == '0);
    endproperty
    a_output_bit_holds: assert property (p_output_bit_holds) else $error("Output bit changed unwritten.");

    property p_output_bit_write;
        @(posedge clk_sys_in) disable iff (srst_in)
        (wr_go && reg_hit(req_idx, ppg_pkg::IDX_LEVEL_LOW) && avs_byteenable_in == 4'hf)
        |=> (($past(dir_low_q) & (level_low_q ^ $past(avs_writedata_in[ppg_pkg::HALF_WIDTH-1:0]))) == '0);
    endproperty
    a_output_bit_write: assert property (p_output_bit_write) else $error("Output bit write lost.");

    property p_en_mid_write;
        @(posedge clk_sys_in) disable iff (srst_in)
        (wr_go && reg_hit(req_idx, ppg_pkg::IDX_EN_MID) && avs_byteenable_in == 4'hf)
        |=> (en_mid_q == $past(avs_writedata_in[ppg_pkg::HALF_WIDTH-1:0]));
    endproperty
    a_en_mid_write: assert property (p_en_mid_write) else $error("Mid enable write not stored.");

    // A cleared byte enable leaves its half of the register as it was.
    property p_lane_keep;
        @(posedge clk_sys_in) disable iff (srst_in)
        (wr_go && reg_hit(req_idx, ppg_pkg::IDX_DIR_LOW) && !avs_byteenable_in[1])
        |=> (dir_low_q[15:8] == $past(dir_low_q[15:8]));
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("Disabled byte lane was written.");

    property p_drive_status_read;
        @(posedge clk_sys_in) disable iff (srst_in)
        (rd_take && reg_hit(req_idx, ppg_pkg::IDX_DRIVE_STAT)) |=> (avs_readdata_out == ~$past(pad_oe_n_out));
    endproperty
    a_drive_status_read: assert property (p_drive_status_read) else $error("Drive status read is wrong.");

    property p_snapshot_read;
        @(posedge clk_sys_in) disable iff (srst_in)
        (rd_take && reg_hit(req_idx, ppg_pkg::IDX_LEVEL_SNAP)) |=> (avs_readdata_out == $past(sync_level));
    endproperty
    a_snapshot_read: assert property (p_snapshot_read) else $error("Level snapshot read is wrong.");

endmodule // ppg_gpio_bank

// file: sim/ppg_board_model.sv
`timescale 1ns/1ps
module ppg_board_model (
    // Pads as seen from the board
    input wire logic [ppg_pkg::PIN_COUNT-1:0] pad_out_in,
    input wire logic [ppg_pkg::PIN_COUNT-1:0] pad_oe_n_in,
    input wire logic [ppg_pkg::PIN_COUNT-1:0] board_level_in,
    // Resolved wire level
    output logic [ppg_pkg::PIN_COUNT-1:0] pad_level_out
);
    // A released pad follows the board driver, so a stale device value never leaks through.
    always_comb
    begin
        for (int i = 0; i < ppg_pkg::PIN_COUNT; i++)
        begin
            pad_level_out[i] = pad_oe_n_in[i] ? board_level_in[i] : pad_out_in[i];
        end
    end
endmodule // ppg_board_model

// file: sim/test_parallel_pin_gpio_bank.sv
`timescale 1ns/1ps
module test_parallel_pin_gpio_bank;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [16:0] avs_address_in = 17'h00000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [15:0] en_lo = 16'h0000;
    logic [15:0] lvl_mid = 16'h0000;
    logic bus_sel = 1'b0;
    logic [31:0] ext = 32'h5a5ac3c3;
    logic [31:0] pad_in;
    logic [31:0] pad_out;
    logic [31:0] pad_oe_n;
    logic [31:0] sync_lvl;
    logic [31:0] exp_q[$];
    int err_total = 0;
    int checks_done = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    ppg_gpio_bank dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .pin_function_enable_low_in(en_lo), .pin_level_mid_in(lvl_mid),
        .bus_select_owns_pins_in(bus_sel), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n_out(pad_oe_n), .pin_level_sync_out(sync_lvl));

    ppg_board_model board (.pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n), .board_level_in(ext),
        .pad_level_out(pad_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic bus(input logic w, input ppg_pkg::ppg_idx_t i, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        avs_address_in <= {i, 2'b00};
        avs_read_in <= ~w;
        avs_write_in <= w;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (n >= 50)
            chk(32'h00000000, 32'h00000001);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input ppg_pkg::ppg_idx_t i, input logic [31:0] d);
        bus(1'b1, i, d, 4'hf);
    endtask

    task automatic rd(input ppg_pkg::ppg_idx_t i, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, i, 32'h00000000, 4'hf);
    endtask

    // Read data are latched on the first cycle and hold until the next read, so they are compared in the cycle of the answer.
    always @(posedge clk_sys_in)
    begin
        if (avs_read_in && avs_waitrequest_out === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk(avs_readdata_out, 32'hffffffff);
            else
                chk(avs_readdata_out, exp_q.pop_front());
        end
    end

    initial
    begin
        #200000;
        err_total++;
        print_verdict();
    end

    initial
    begin
        int s;
        logic [15:0] d;
        logic [15:0] v;
        logic [15:0] e;
        logic [15:0] d2;
        logic [31:0] drv;
        logic [31:0] val;
        logic [31:0] padx;
        s = $urandom(32'h37ea09a2);
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rd(ppg_pkg::IDX_DIR_LOW, 32'h00000000);
        rd(ppg_pkg::IDX_EN_MID, 32'h00000000);
        rd(ppg_pkg::IDX_DIR_MID, 32'h00000000);
        rd(ppg_pkg::IDX_LEVEL_LOW, {16'h0000, ext[15:0]});
        rd(15'h4405, 32'h00000000);
        wr(ppg_pkg::IDX_DRIVE_STAT, 32'hffffffff);
        rd(ppg_pkg::IDX_DRIVE_STAT, 32'h00000000);
        wr(ppg_pkg::IDX_DIR_LOW, 32'h0000ffff);
        bus(1'b1, ppg_pkg::IDX_DIR_LOW, 32'h00000000, 4'h1);
        rd(ppg_pkg::IDX_DIR_LOW, 32'h0000ff00);
        for (int k = 0; k < 8; k++)
        begin
            d = 16'($urandom());
            v = 16'($urandom());
            e = (k == 1) ? 16'h0000 : 16'($urandom());
            d2 = 16'($urandom());
            en_lo <= (k == 2) ? 16'h0000 : 16'($urandom());
            lvl_mid <= 16'($urandom());
            bus_sel <= (k == 3);
            ext <= $urandom();
            wr(ppg_pkg::IDX_DIR_LOW, {16'h0000, d});
            wr(ppg_pkg::IDX_EN_MID, {16'h0000, e});
            wr(ppg_pkg::IDX_DIR_MID, {16'h0000, d2});
            wr(ppg_pkg::IDX_LEVEL_LOW, {16'h0000, v});
            repeat (4) @(posedge clk_sys_in);
            #1;
            drv = bus_sel ? 32'h00000000 : {e & d2, en_lo & d};
            val = {lvl_mid, v};
            padx = (drv & val) | (~drv & ext);
            chk(pad_oe_n, ~drv);
            chk(pad_out & drv, val & drv);
            chk(sync_lvl, padx);
            rd(ppg_pkg::IDX_DIR_LOW, {16'h0000, d});
            rd(ppg_pkg::IDX_EN_MID, {16'h0000, e});
            rd(ppg_pkg::IDX_DIR_MID, {16'h0000, d2});
            rd(ppg_pkg::IDX_LEVEL_LOW, {16'h0000, (d & v) | (~d & padx[15:0])});
            rd(ppg_pkg::IDX_LEVEL_SNAP, padx);
            rd(ppg_pkg::IDX_DRIVE_STAT, drv);
        end
        // A second reset in mid-run must release every pin and reload the data bits from the pads.
        srst_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        chk(pad_oe_n, 32'hffffffff);
        rd(ppg_pkg::IDX_DIR_LOW, 32'h00000000);
        rd(ppg_pkg::IDX_LEVEL_LOW, {16'h0000, ext[15:0]});
        repeat (3) @(posedge clk_sys_in);
        chk(32'(exp_q.size()), 32'h00000000);
        print_verdict();
    end
endmodule // test_parallel_pin_gpio_bank
